// ---- include/flag_unit_pkg.sv ----
package flag_unit_pkg;

	// ****************************************************************
	// register map (byte addresses on APB; printed offsets are words)
	// ****************************************************************
	localparam logic [7:0] IMASK_INDEX = 8'hFB;
	localparam logic [7:0] FLAGS_INDEX = 8'hFC;
	localparam logic [7:0] WGP_INDEX = 8'hFD;
	localparam logic [11:0] IMASK_ADDR = 12'h3EC;
	localparam logic [11:0] FLAGS_ADDR = 12'h3F0;
	localparam logic [11:0] WGP_ADDR = 12'h3F4;
	localparam logic [11:0] OPSTAT_ADDR = 12'h000;
	localparam logic [7:0] IMASK_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] WGP_RESET = 8'h00;

	// ****************************************************************
	// flag bit positions in the status flag register
	// ****************************************************************
	localparam int CARRY_BIT = 7;
	localparam int ZERO_BIT = 6;
	localparam int SIGN_BIT = 5;
	localparam int RANGE_BIT = 4;
	localparam int MINUS_BIT = 3;
	localparam int NIBBLE_BIT = 2;

	// ****************************************************************
	// operation classes issued by the datapath
	// ****************************************************************
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ADD = 3'h1,
		OP_SUB = 3'h3,
		OP_LOGIC = 3'h2,
		OP_SHIFT = 3'h6,
		OP_BCD = 3'h7,
		OP_RESTORE = 3'h5,
		OP_WRITE = 3'h4
	} op_class_t;

	typedef struct packed {
		op_class_t opClass;
		logic [7:0] opA;
		logic [7:0] opB;
		logic carryIn;
		logic [7:0] shiftResult;
		logic shiftCarry;
		logic [7:0] savedFlags;
	} flag_req_t;

	typedef struct packed {
		logic carry;
		logic zero;
		logic sign;
		logic range;
		logic minus;
		logic nibble;
	} flag_set_t;

	// condition selector values
	localparam logic [3:0] CC_NEVER = 4'h0;
	localparam logic [3:0] CC_SIGNED_BELOW = 4'h1;
	localparam logic [3:0] CC_SIGNED_AT_MOST = 4'h2;
	localparam logic [3:0] CC_UNSIGNED_AT_MOST = 4'h3;
	localparam logic [3:0] CC_RANGE_ERROR = 4'h4;
	localparam logic [3:0] CC_SIGN_SET = 4'h5;
	localparam logic [3:0] CC_ZERO = 4'h6;
	localparam logic [3:0] CC_CARRY = 4'h7;
	localparam logic [3:0] CC_ALWAYS = 4'h8;
	localparam logic [3:0] CC_SIGNED_AT_LEAST = 4'h9;
	localparam logic [3:0] CC_SIGNED_ABOVE = 4'hA;
	localparam logic [3:0] CC_UNSIGNED_ABOVE = 4'hB;
	localparam logic [3:0] CC_NO_RANGE_ERROR = 4'hC;
	localparam logic [3:0] CC_SIGN_CLEAR = 4'hD;
	localparam logic [3:0] CC_NOT_NULL = 4'hE;
	localparam logic [3:0] CC_NO_CARRY = 4'hF;
	localparam int CC_MSB = 7;
	localparam int CC_LSB = 4;

	// pack and unpack flags to the register layout
	function automatic logic [7:0] pack_flags(input flag_set_t f);
		logic [7:0] v;
		v = 8'h00;
		v[CARRY_BIT] = f.carry;
		v[ZERO_BIT] = f.zero;
		v[SIGN_BIT] = f.sign;
		v[RANGE_BIT] = f.range;
		v[MINUS_BIT] = f.minus;
		v[NIBBLE_BIT] = f.nibble;
		return v;
	endfunction : pack_flags

	function automatic flag_set_t unpack_flags(input logic [7:0] v);
		flag_set_t f;
		f.carry = v[CARRY_BIT];
		f.zero = v[ZERO_BIT];
		f.sign = v[SIGN_BIT];
		f.range = v[RANGE_BIT];
		f.minus = v[MINUS_BIT];
		f.nibble = v[NIBBLE_BIT];
		return f;
	endfunction : unpack_flags

endpackage : flag_unit_pkg

// ---- src/condition_eval.sv ----
// ********************************************************************
// combinational jump predicate decode
// ********************************************************************
module condition_eval (
	input wire logic [7:0] opcode,
	input wire flag_unit_pkg::flag_set_t flags,
	output logic taken
);
	logic [3:0] sel;
	logic signedLess;

	// selector is the opcode's upper nibble
	// selector from opcode
	assign sel = opcode[flag_unit_pkg::CC_MSB:flag_unit_pkg::CC_LSB];
	assign signedLess = flags.sign ^ flags.range;

	always_comb begin
		case (sel)
			flag_unit_pkg::CC_NEVER: taken = 1'b0;
			flag_unit_pkg::CC_ALWAYS: taken = 1'b1;
			flag_unit_pkg::CC_CARRY: taken = flags.carry;
			flag_unit_pkg::CC_NO_CARRY: taken = ~flags.carry;
			flag_unit_pkg::CC_ZERO: taken = flags.zero;
			flag_unit_pkg::CC_NOT_NULL: taken = ~flags.zero;
			flag_unit_pkg::CC_SIGN_SET: taken = flags.sign;
			flag_unit_pkg::CC_SIGN_CLEAR: taken = ~flags.sign;
			flag_unit_pkg::CC_RANGE_ERROR: taken = flags.range;
			flag_unit_pkg::CC_NO_RANGE_ERROR: taken = ~flags.range;
			flag_unit_pkg::CC_SIGNED_AT_LEAST: taken = ~signedLess;
			flag_unit_pkg::CC_SIGNED_BELOW: taken = signedLess;
			flag_unit_pkg::CC_SIGNED_ABOVE: taken = ~(flags.zero | signedLess);
			flag_unit_pkg::CC_SIGNED_AT_MOST: taken = flags.zero | signedLess;
			flag_unit_pkg::CC_UNSIGNED_ABOVE: taken = ~(flags.carry | flags.zero);
			flag_unit_pkg::CC_UNSIGNED_AT_MOST: taken = flags.carry | flags.zero;
			default: taken = 1'b0;
		endcase
	end
endmodule : condition_eval

// ---- src/operand_range.sv ----
// ********************************************************************
// operand range shaping for addressing modes
// ********************************************************************
module operand_range (
	input wire logic [7:0] operand,
	input wire logic [15:0] nextPc,
	input wire logic [3:0] indexSel,
	output logic [7:0] pairAddr,
	output logic [3:0] workPairSel,
	output logic [15:0] relTarget,
	output logic [7:0] indexBase,
	output logic [3:0] indexReg
);
	assign pairAddr = {operand[7:1], 1'b0};
	assign workPairSel = {operand[3:1], 1'b0};
	assign relTarget = nextPc + {{8{operand[7]}}, operand};
	assign indexBase = operand;
	assign indexReg = indexSel;
endmodule : operand_range

// ---- src/cpu_flag_and_condition_unit.sv ----
// Contract
// - signed add/sub/shift sets range flag on result beyond 127 or -128
// - logical ops clear range flag
// - interrupt return reloads range, minus and nibble flags from stack copy
// - subtraction sets minus flag, addition clears it
// - jumps test only carry, zero, sign and range flags
// - nibble carry on carry out of or borrow into bit 3
// - bcd correction uses nibble and minus flags
// - selector is opcode bits 4 to 7
// - 0000 never true, 1000 always true
// - single-flag selectors decoded per flag sense
// - signed comparisons from sign xor range term
// - unsigned comparisons from carry and zero
// - register pairs even only, working pairs even 0 to 14
// - relative byte is signed offset from next instruction
// - immediate, register and direct operands span 00h to FFh
// - indexed operand is 8-bit base plus selector 0 to 15
// - interrupt mask at FBh, flags at FCh, pointer at FDh
// - carry on carry out of or borrow into bit 7
// - zero flag set when result is zero
// - sign flag copies result bit 7
//
// The APB register port was left to the implementer.
module cpu_flag_and_condition_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire flag_unit_pkg::flag_req_t req,
	input wire logic reqValid,
	input wire logic [7:0] opcode,
	input wire logic [7:0] operand,
	input wire logic [15:0] nextPc,
	input wire logic [3:0] indexSel,
	output logic [7:0] result,
	output logic jumpTaken,
	output logic [7:0] pairAddr,
	output logic [3:0] workPairSel,
	output logic [15:0] relTarget,
	output logic [7:0] indexBase,
	output logic [3:0] indexReg,
	output logic [7:0] flagsOut,
	output logic [7:0] interruptMask,
	output logic [7:0] workingGroupPointer,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] imask_reg;
	logic [7:0] wgp_reg;
	logic [7:0] result_reg;
	logic [7:0] result_next;
	logic [7:0] opcount_reg;
	flag_unit_pkg::flag_set_t cur;
	flag_unit_pkg::flag_set_t upd;

	assign cur = flag_unit_pkg::unpack_flags(flags_reg);

	// ****************************************************************
	// arithmetic
	// ****************************************************************
	logic isSub;
	logic [8:0] sum9;
	logic [4:0] low5;
	logic [7:0] bSel;
	logic [7:0] logicRes;
	logic [7:0] bcdAdj;
	logic [8:0] bcdSum;
	logic bcdLow;
	logic bcdHigh;

	assign isSub = (req.opClass == flag_unit_pkg::OP_SUB);
	// subtraction is done as add of inverted operand; borrow = ~carry
	assign bSel = isSub ? ~req.opB : req.opB;
	assign sum9 = {1'b0, req.opA} + {1'b0, bSel}
		+ {8'h00, req.carryIn ^ isSub};
	assign low5 = {1'b0, req.opA[3:0]} + {1'b0, bSel[3:0]}
		+ {4'h0, req.carryIn ^ isSub};
	// logical class is an AND, OR or XOR done by the datapath; opB carries
	// the already combined value so the flag logic stays class-generic
	assign logicRes = req.opB;

	// correction terms depend on last op direction and the nibble carry
	// bcd uses nibble and minus
	assign bcdLow = cur.nibble | (~cur.minus & (req.opA[3:0] > 4'h9));
	assign bcdHigh = cur.carry | (~cur.minus & (req.opA > 8'h99));
	assign bcdAdj = {(bcdHigh ? 4'h6 : 4'h0), (bcdLow ? 4'h6 : 4'h0)};
	assign bcdSum = cur.minus ? ({1'b0, req.opA} - {1'b0, bcdAdj})
		: ({1'b0, req.opA} + {1'b0, bcdAdj});

	// flag update by operation class
	always_comb begin
		upd = cur;
		result_next = result_reg;
		flags_next = flags_reg;
		case (req.opClass)
			flag_unit_pkg::OP_ADD, flag_unit_pkg::OP_SUB: begin
				result_next = sum9[7:0];
				// carry or borrow at bit 7
				upd.carry = sum9[8] ^ isSub;
				upd.zero = (sum9[7:0] == 8'h00);
				upd.sign = sum9[7];
				upd.range = (req.opA[7] == bSel[7]) && (sum9[7] != req.opA[7]);
				upd.minus = isSub;
				upd.nibble = low5[4] ^ isSub;
				flags_next = flag_unit_pkg::pack_flags(upd);
			end
			flag_unit_pkg::OP_LOGIC: begin
				result_next = logicRes;
				upd.zero = (logicRes == 8'h00);
				upd.sign = logicRes[7];
				upd.range = 1'b0;
				flags_next = flag_unit_pkg::pack_flags(upd);
			end
			flag_unit_pkg::OP_SHIFT: begin
				result_next = req.shiftResult;
				upd.carry = req.shiftCarry;
				upd.zero = (req.shiftResult == 8'h00);
				upd.sign = req.shiftResult[7];
				// sign changed by the shift means out of range
				upd.range = req.shiftResult[7] ^ req.opA[7];
				flags_next = flag_unit_pkg::pack_flags(upd);
			end
			flag_unit_pkg::OP_BCD: begin
				result_next = bcdSum[7:0];
				upd.carry = bcdHigh;
				upd.zero = (bcdSum[7:0] == 8'h00);
				upd.sign = bcdSum[7];
				flags_next = flag_unit_pkg::pack_flags(upd);
			end
			flag_unit_pkg::OP_RESTORE: begin
				flags_next = req.savedFlags;
			end
			flag_unit_pkg::OP_WRITE: begin
				// plain load keeps flags as written; no flag side effect
				flags_next = req.savedFlags;
			end
			default: begin
				flags_next = flags_reg;
			end
		endcase
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	logic access;
	logic wrAccess;
	logic hitFlags;
	logic hitImask;
	logic hitWgp;
	logic hitStat;
	logic mapped;
	logic dpWrite;

	// single-cycle access phase: no wait states
	assign pready = 1'b1;
	assign access = psel & penable;
	assign wrAccess = access & pwrite;
	assign hitImask = (paddr == flag_unit_pkg::IMASK_ADDR);
	assign hitFlags = (paddr == flag_unit_pkg::FLAGS_ADDR);
	assign hitWgp = (paddr == flag_unit_pkg::WGP_ADDR);
	assign hitStat = (paddr == flag_unit_pkg::OPSTAT_ADDR);
	assign mapped = hitImask | hitFlags | hitWgp | hitStat;
	assign pslverr = access & ~mapped;
	assign dpWrite = reqValid & (req.opClass != flag_unit_pkg::OP_NONE);

	// read mux, narrow registers in the low byte
	always_comb begin
		prdata = 32'h00000000;
		if (hitImask) begin
			prdata = {24'h000000, imask_reg};
		end else if (hitFlags) begin
			prdata = {24'h000000, flags_reg};
		end else if (hitWgp) begin
			prdata = {24'h000000, wgp_reg};
		end else if (hitStat) begin
			prdata = {24'h000000, opcount_reg};
		end
	end

	// flag register: datapath update wins over a bus write in same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_reg <= flag_unit_pkg::FLAGS_RESET;
			result_reg <= 8'h00;
		end else if (ce) begin
			if (dpWrite) begin
				flags_reg <= flags_next;
				result_reg <= result_next;
			end else if (wrAccess && hitFlags) begin
				flags_reg <= pwdata[7:0];
			end
		end
	end

	// control registers, bus only
	always_ff @(posedge clk) begin
		if (rst) begin
			imask_reg <= flag_unit_pkg::IMASK_RESET;
			wgp_reg <= flag_unit_pkg::WGP_RESET;
		end else if (ce && wrAccess) begin
			if (hitImask) begin
				imask_reg <= pwdata[7:0];
			end
			if (hitWgp) begin
				wgp_reg <= pwdata[7:0];
			end
		end
	end

	// count of flag updates, read-only state for software
	always_ff @(posedge clk) begin
		if (rst) begin
			opcount_reg <= 8'h00;
		end else if (ce && dpWrite) begin
			opcount_reg <= opcount_reg + 8'h01;
		end
	end

	assign result = result_reg;
	assign flagsOut = flags_reg;
	assign interruptMask = imask_reg;
	assign workingGroupPointer = wgp_reg;

	// ****************************************************************
	// condition and operand decode
	// ****************************************************************
	// predicate straight from flags
	condition_eval u_cond (
		.opcode(opcode),
		.flags(cur),
		.taken(jumpTaken)
	);

	operand_range u_range (
		.operand(operand),
		.nextPc(nextPc),
		.indexSel(indexSel),
		.pairAddr(pairAddr),
		.workPairSel(workPairSel),
		.relTarget(relTarget),
		.indexBase(indexBase),
		.indexReg(indexReg)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	a_logic_clears_range: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_LOGIC
		|=> !flags_reg[flag_unit_pkg::RANGE_BIT])
		else $error("range flag not cleared by logical op");
	a_minus_on_sub: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_SUB
		|=> flags_reg[flag_unit_pkg::MINUS_BIT])
		else $error("minus flag not set after subtraction");
	a_minus_on_add: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_ADD
		|=> !flags_reg[flag_unit_pkg::MINUS_BIT])
		else $error("minus flag not cleared after addition");
	a_restore_loads: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_RESTORE
		|=> flags_reg == $past(req.savedFlags))
		else $error("restored flags differ from stack copy");
	a_zero_matches: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_ADD
		|=> flags_reg[flag_unit_pkg::ZERO_BIT] == (result == 8'h00))
		else $error("zero flag disagrees with result");
	a_sign_matches: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_LOGIC
		|=> flags_reg[flag_unit_pkg::SIGN_BIT] == result[7])
		else $error("sign flag disagrees with result bit 7");
	a_never_taken: assert property (@(posedge clk) disable iff (rst)
		opcode[7:4] == flag_unit_pkg::CC_NEVER |-> !jumpTaken)
		else $error("never selector taken");
	a_always_taken: assert property (@(posedge clk) disable iff (rst)
		opcode[7:4] == flag_unit_pkg::CC_ALWAYS |-> jumpTaken)
		else $error("always selector not taken");
	a_signed_below: assert property (@(posedge clk) disable iff (rst)
		opcode[7:4] == flag_unit_pkg::CC_SIGNED_BELOW
		|-> jumpTaken == (flags_reg[5] ^ flags_reg[4]))
		else $error("signed below decode wrong");
	a_pair_even: assert property (@(posedge clk) disable iff (rst)
		!pairAddr[0] && !workPairSel[0])
		else $error("odd register pair address");
	a_add_nibble: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_ADD
		&& ({1'b0, req.opA[3:0]} + {1'b0, req.opB[3:0]}
		+ {4'h0, req.carryIn}) > 5'h0F
		|=> flags_reg[flag_unit_pkg::NIBBLE_BIT])
		else $error("nibble carry missing after addition");
	a_add_carry: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_ADD
		&& ({1'b0, req.opA} + {1'b0, req.opB}
		+ {8'h00, req.carryIn}) > 9'h0FF
		|=> flags_reg[flag_unit_pkg::CARRY_BIT])
		else $error("carry missing after addition");
	a_add_no_carry: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_ADD
		&& ({1'b0, req.opA} + {1'b0, req.opB}
		+ {8'h00, req.carryIn}) <= 9'h0FF
		|=> !flags_reg[flag_unit_pkg::CARRY_BIT])
		else $error("carry set without carry out");
	a_sub_zero: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_SUB
		|=> flags_reg[flag_unit_pkg::ZERO_BIT] == (result == 8'h00))
		else $error("zero flag disagrees with difference");
	a_shift_sign: assert property (@(posedge clk) disable iff (rst)
		ce && reqValid && req.opClass == flag_unit_pkg::OP_SHIFT
		|=> flags_reg[flag_unit_pkg::SIGN_BIT] == result[7])
		else $error("sign flag disagrees with shifted bit 7");
	a_no_carry_taken: assert property (@(posedge clk) disable iff (rst)
		opcode[7:4] == flag_unit_pkg::CC_NO_CARRY
		|-> jumpTaken == !flags_reg[flag_unit_pkg::CARRY_BIT])
		else $error("no carry selector decode wrong");
	a_sign_clear: assert property (@(posedge clk) disable iff (rst)
		opcode[7:4] == flag_unit_pkg::CC_SIGN_CLEAR
		|-> jumpTaken == !flags_reg[flag_unit_pkg::SIGN_BIT])
		else $error("sign clear selector decode wrong");
	a_signed_above: assert property (@(posedge clk) disable iff (rst)
		opcode[7:4] == flag_unit_pkg::CC_SIGNED_ABOVE
		|-> jumpTaken == !(flags_reg[6] | (flags_reg[5] ^ flags_reg[4])))
		else $error("signed above decode wrong");
	a_unsigned_above: assert property (@(posedge clk) disable iff (rst)
		opcode[7:4] == flag_unit_pkg::CC_UNSIGNED_ABOVE
		|-> jumpTaken == !(flags_reg[7] | flags_reg[6]))
		else $error("unsigned above decode wrong");
	a_flags_readback: assert property (@(posedge clk) disable iff (rst)
		psel && penable && paddr == flag_unit_pkg::FLAGS_ADDR
		|-> prdata == {24'h000000, flags_reg})
		else $error("flag register read returns wrong data");

endmodule : cpu_flag_and_condition_unit

// ---- verification/datapath_partner.sv ----
// ********************************************************************
// execution datapath stand-in: issues one flag request per call
// ********************************************************************
module datapath_partner (
	input wire logic clk,
	output flag_unit_pkg::flag_req_t req,
	output logic reqValid
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle state before the first call
	initial begin
		req = '0;
		reqValid = 1'b0;
	end

	// fields are inverted when idle so stale operands can never match
	task automatic send(input flag_unit_pkg::flag_req_t r);
		@(posedge clk);
		req <= r;
		reqValid <= 1'b1;
		@(posedge clk);
		reqValid <= 1'b0;
		req <= ~r;
	endtask : send
endmodule : datapath_partner

// ---- verification/test_cpu_flag_and_condition_unit.sv ----
module test_cpu_flag_and_condition_unit;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CB = flag_unit_pkg::CARRY_BIT;
	localparam int ZB = flag_unit_pkg::ZERO_BIT;
	localparam int SB = flag_unit_pkg::SIGN_BIT;
	localparam int VB = flag_unit_pkg::RANGE_BIT;
	localparam int DB = flag_unit_pkg::MINUS_BIT;
	localparam int HB = flag_unit_pkg::NIBBLE_BIT;
	logic clk, rst, ce, reqValid, jumpTaken, psel, penable, pwrite;
	logic pready, pslverr, err;
	flag_unit_pkg::flag_req_t req, r;
	logic [7:0] opcode, operand, result, pairAddr, indexBase, flagsOut;
	logic [7:0] interruptMask, workingGroupPointer, model, res;
	logic [15:0] nextPc, relTarget;
	logic [3:0] indexSel, workPairSel, indexReg;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, d;
	logic [23:0] regOuts;
	int seed, badCount, nChecks;
	logic [11:0] addrs [3] = '{flag_unit_pkg::IMASK_ADDR,
		flag_unit_pkg::FLAGS_ADDR, flag_unit_pkg::WGP_ADDR};
	// the flag register keeps all eight written bits, spare ones too
	logic [7:0] masks [3] = '{8'hFF, 8'hFF, 8'hFF};
	// each bcd correction follows an addition or a subtraction
	flag_unit_pkg::op_class_t cls [8] = '{flag_unit_pkg::OP_ADD,
		flag_unit_pkg::OP_BCD, flag_unit_pkg::OP_SUB, flag_unit_pkg::OP_BCD,
		flag_unit_pkg::OP_LOGIC, flag_unit_pkg::OP_SHIFT,
		flag_unit_pkg::OP_RESTORE, flag_unit_pkg::OP_WRITE};

	// register outputs in the same order as the address table
	assign regOuts = {workingGroupPointer, flagsOut, interruptMask};

	// free-running 250 MHz clock
	always #2 clk = ~clk;

	cpu_flag_and_condition_unit cpu_flag_and_condition_unit_inst (
		.clk(clk), .rst(rst), .ce(ce), .req(req), .reqValid(reqValid),
		.opcode(opcode), .operand(operand), .nextPc(nextPc),
		.indexSel(indexSel), .result(result), .jumpTaken(jumpTaken),
		.pairAddr(pairAddr), .workPairSel(workPairSel),
		.relTarget(relTarget), .indexBase(indexBase), .indexReg(indexReg),
		.flagsOut(flagsOut), .interruptMask(interruptMask),
		.workingGroupPointer(workingGroupPointer), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	datapath_partner datapath_partner_inst (
		.clk(clk), .req(req), .reqValid(reqValid));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		nChecks++;
		if (got !== exp) begin
			badCount++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// one transfer; an idle cycle first so strobes never toggle twice
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] v);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 20) begin
			badCount++;
			$display("[FAIL] %0t bus wait expired", $time);
			summarize();
		end
	endtask : apb

	// expected flags and result; untouched flags keep their old value
	function automatic logic [7:0] calcFlags(
		input flag_unit_pkg::flag_req_t q, input logic [7:0] old,
		output logic [7:0] y);
		logic [8:0] s;
		logic [7:0] f;
		logic lo, hi;
		logic [7:0] adj;
		f = old;
		y = 8'h00;
		case (q.opClass)
			flag_unit_pkg::OP_ADD: begin
				s = q.opA + q.opB + q.carryIn;
				y = s[7:0];
				f[CB] = s[8];
				f[DB] = 1'b0;
				f[HB] = {1'b0, q.opA[3:0]} + q.opB[3:0] + q.carryIn > 15;
				f[VB] = q.opA[7] == q.opB[7] && y[7] != q.opA[7];
			end
			flag_unit_pkg::OP_SUB: begin
				s = {1'b0, q.opA} - q.opB - q.carryIn;
				y = s[7:0];
				f[CB] = s[8];
				f[DB] = 1'b1;
				f[HB] = {1'b0, q.opA[3:0]} < q.opB[3:0] + q.carryIn;
				f[VB] = q.opA[7] != q.opB[7] && y[7] != q.opA[7];
			end
			flag_unit_pkg::OP_LOGIC: begin
				y = q.opB;
				f[VB] = 1'b0;
			end
			flag_unit_pkg::OP_SHIFT: begin
				y = q.shiftResult;
				f[CB] = q.shiftCarry;
				f[VB] = y[7] ^ q.opA[7];
			end
			// direction from the minus flag, sixes from nibble and carry
			flag_unit_pkg::OP_BCD: begin
				lo = old[HB] | (~old[DB] & (q.opA[3:0] > 4'h9));
				hi = old[CB] | (~old[DB] & (q.opA > 8'h99));
				adj = {(hi ? 4'h6 : 4'h0), (lo ? 4'h6 : 4'h0)};
				y = old[DB] ? q.opA - adj : q.opA + adj;
				f[CB] = hi;
			end
			// restore and plain load take the saved byte whole
			default: return q.savedFlags;
		endcase
		f[ZB] = y == 8'h00;
		f[SB] = y[7];
		return f & 8'hFC;
	endfunction : calcFlags

	// low three selector bits pick a term, the top bit inverts it
	function automatic logic predicate(input logic [3:0] cc,
		input logic [7:0] f);
		logic t;
		t = f[SB] ^ f[VB];
		case (cc[2:0])
			3'h0: t = 1'b0;
			3'h2: t = f[ZB] | t;
			3'h3: t = f[CB] | f[ZB];
			3'h4: t = f[VB];
			3'h5: t = f[SB];
			3'h6: t = f[ZB];
			3'h7: t = f[CB];
			default: t = t;
		endcase
		return t ^ cc[3];
	endfunction : predicate

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		opcode = 8'h00;
		operand = 8'h00;
		nextPc = 16'h0000;
		indexSel = 4'h0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		seed = 32'he0dc46bd;
		badCount = 0;
		nChecks = 0;
		model = 8'h00;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// reset values, write then read back through the bus
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, addrs[i], 32'h0);
			check(rd, 32'h0, "reset value");
			d = $random(seed);
			apb(1'b1, addrs[i], d);
			#1;
			check(regOuts[i*8 +: 8], d[7:0] & masks[i], "reg out");
			apb(1'b0, addrs[i], 32'h0);
			check(rd, {24'h0, d[7:0] & masks[i]}, "readback");
			check(err, 1'b0, "mapped error");
			if (i == 1) begin
				model = d[7:0];
			end
		end
		// unmapped places refuse and leave the flag register alone
		apb(1'b1, 12'h104, 32'hFFFF_FFFF);
		check(err, 1'b1, "unmapped write");
		apb(1'b0, 12'h100, 32'h0);
		check(err, 1'b1, "unmapped read");
		check(rd, 32'h0, "unmapped data");
		check(flagsOut, model, "flags kept");
		$display("test registers done");
		// random operations, each followed by all sixteen selectors
		for (int n = 0; n < 240; n++) begin
			r = 37'({$random(seed), $random(seed)});
			r.opClass = cls[n % 8];
			if (n == 0 || n == 2) begin
				r.opA = n ? 8'h80 : 8'h7F;
				r.opB = 8'h01;
				r.carryIn = 1'b0;
			end
			// correction works on the result it follows
			if (r.opClass == flag_unit_pkg::OP_BCD) begin
				r.opA = res;
			end
			model = calcFlags(r, model, res);
			datapath_partner_inst.send(r);
			#1;
			check(flagsOut, model, "flags");
			if (n % 8 < 6) begin
				check(result, res, "result");
			end
			for (int c = 0; c < 16; c++) begin
				@(posedge clk);
				opcode <= {4'(c), 4'($random(seed))};
				#1;
				check(jumpTaken, predicate(4'(c), model), "jump");
			end
		end
		// a held clock enable freezes the flags
		@(posedge clk);
		ce <= 1'b0;
		r.opClass = flag_unit_pkg::OP_RESTORE;
		r.savedFlags = ~model;
		datapath_partner_inst.send(r);
		#1;
		check(flagsOut, model, "frozen flags");
		@(posedge clk);
		ce <= 1'b1;
		// 240 updates counted; the request made while frozen is not
		apb(1'b0, flag_unit_pkg::OPSTAT_ADDR, 32'h0);
		check(rd, 32'h0000_00F0, "update count");
		check(err, 1'b0, "count error");
		check(pready, 1'b1, "ready");
		$display("test flags and jumps done");
		// operand shaping, signed extremes first
		for (int n = 0; n < 64; n++) begin
			@(posedge clk);
			d = $random(seed);
			if (n < 2) begin
				d[7:0] = n ? 8'h80 : 8'h7F;
			end
			operand <= d[7:0];
			nextPc <= d[23:8];
			indexSel <= d[27:24];
			#1;
			check(pairAddr, d[7:0] & 8'hFE, "pair");
			check(workPairSel, {d[3:1], 1'b0}, "work pair");
			check(relTarget, 16'(d[23:8] + {{8{d[7]}}, d[7:0]}), "rel");
			check(indexBase, d[7:0], "base");
			check(indexReg, d[27:24], "index");
		end
		$display("test operands done");
		summarize();
	end
endmodule : test_cpu_flag_and_condition_unit
